// ===== design/fscw_defs.svh
`ifndef FSCW_DEFS_SVH
`define FSCW_DEFS_SVH

// status word fields
`define FSCW_SW_EXC_LO     0
`define FSCW_SW_EXC_HI     5
`define FSCW_SW_STKFLT     6
`define FSCW_SW_ERRSUM     7
`define FSCW_SW_COND0      8
`define FSCW_SW_COND1      9
`define FSCW_SW_COND2      10
`define FSCW_SW_COND3      11
`define FSCW_SW_TOP_LO     12
`define FSCW_SW_TOP_HI     14
`define FSCW_SW_BUSY       15
// control word fields
`define FSCW_CW_MASK_LO    0
`define FSCW_CW_MASK_HI    5
`define FSCW_CW_PREC_LO    8
`define FSCW_CW_PREC_HI    9
`define FSCW_CW_RND_LO     10
`define FSCW_CW_RND_HI     11
// exception flag positions
`define FSCW_EXC_INVALID   0
`define FSCW_EXC_INEXACT   5
// reset and init values
`define FSCW_CW_INIT       16'h037F
`define FSCW_SW_INIT       16'h0000
`define FSCW_TAG_EMPTY     2'h3
`define FSCW_TAG_VALID     2'h0
`define FSCW_TAG_ZERO      2'h1
`define FSCW_TAG_SPECIAL   2'h2
`define FSCW_TW_INIT       16'hFFFF
`define FSCW_NREGS         8
`define FSCW_TOP_ONE       3'h1
`define FSCW_TOP_INIT      3'h0
`define FSCW_EXC_NONE      6'h00
`define FSCW_COND_NONE     4'h0

`endif

// ===== design/fscw_pkg.sv
package fscw_pkg;
  typedef enum logic [3:0] {
    FSCW_OP_NONE    = 4'b0000,
    FSCW_OP_INIT    = 4'b0001,
    FSCW_OP_CLEX    = 4'b0010,
    FSCW_OP_LDENV   = 4'b0011,
    FSCW_OP_STENV   = 4'b0100,
    FSCW_OP_SAVE    = 4'b0101,
    FSCW_OP_RSTOR   = 4'b0110,
    FSCW_OP_LDCW    = 4'b0111,
    FSCW_OP_STSW    = 4'b1000,
    FSCW_OP_ARITH   = 4'b1001,
    FSCW_OP_TRIG    = 4'b1010,
    FSCW_OP_COND    = 4'b1011,
    FSCW_OP_STACK   = 4'b1100
  } fscw_op_t;

  typedef enum logic [1:0] {
    FSCW_RND_NEAR  = 2'b00,
    FSCW_RND_DOWN  = 2'b01,
    FSCW_RND_UP    = 2'b10,
    FSCW_RND_CHOP  = 2'b11
  } fscw_rnd_t;

  typedef enum logic [1:0] {
    FSCW_PREC_24   = 2'b00,
    FSCW_PREC_RSV  = 2'b01,
    FSCW_PREC_53   = 2'b10,
    FSCW_PREC_64   = 2'b11
  } fscw_prec_t;

  typedef enum logic [1:0] {
    FSCW_STK_NONE  = 2'b00,
    FSCW_STK_PUSH  = 2'b01,
    FSCW_STK_POP   = 2'b10
  } fscw_stk_t;
endpackage

// ===== design/fscw_state_words.sv
// Operation
// - rounding arithmetic sets condition bit one to roundup unless a stack fault.
// - trig ops set condition bit two 1 when operand too large, else 0.
// - load environment or restore loads all condition bits from memory image.
// - integer flags: cond0 to carry, cond2 to parity, cond3 to zero.
// - exception flags sticky; only init, clear, ldenv, save, restore clear.
// - stack overflow or underflow invalid operation sets stack fault bit 6.
// - with stack fault set, bit 9 is 1 overflow, 0 underflow.
// - control word loads as one word; bits 0-5 are exception masks.
// - control bits 8-9 select operating precision, default 64-bit.
// - precision affects only add, sub, mul, div and sqrt results.
// - control bits 10-11 select rounding mode.
// - rounding mode applies only to arithmetic and trig instructions.
// - one tag per physical register 0-7, telling empty from nonempty.
// - store environment and save compute exact tags from register contents.
// - load environment and restore take tags from memory; others only mark tags empty or nonempty.
// - status bits 12-14 hold top index; push decrements, pop increments.
// - error summary set when any unmasked exception flag set, else cleared.
// - status bit 15 mirrors the error summary bit 7.
`timescale 1ns/1ps
`include "fscw_defs.svh"

module fscw_state_words
  import fscw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // instruction strobe from the integer unit
  input  wire logic        opValid,
  input  wire fscw_op_t    opCode,
  input  wire logic [15:0] memWord,
  input  wire logic [15:0] memTags,
  // datapath results
  input  wire logic [5:0]  excRaised,
  input  wire logic        stackFault,
  input  wire logic        stackOverflow,
  input  wire logic        roundedUp,
  input  wire logic        trigTooLarge,
  input  wire logic [3:0]  compareCond,
  input  wire fscw_stk_t   stackMove,
  input  wire logic [2:0]  tagReg,
  input  wire logic        tagWrite,
  input  wire logic        tagFull,
  input  wire logic [15:0] exactTags,
  // architectural words
  output logic [15:0]      fpu_state_word,
  output logic [15:0]      fpu_option_word,
  output logic [15:0]      register_occupancy_tags,
  // decoded controls for the datapath
  output logic [1:0]       precision_select,
  output logic [1:0]       roundingSelect,
  output logic             precisionApplies,
  output logic             roundingApplies,
  // integer flag copy
  output logic             integer_carry_flag,
  output logic             integer_parity_flag,
  output logic             integer_zero_flag
);

  logic [5:0]  excFlags_r;
  logic [5:0]  excFlags_nxt;
  logic        stackFaultFlag_r;
  logic        stackFaultFlag_nxt;
  logic [3:0]  cond_r;
  logic [3:0]  cond_nxt;
  logic [2:0]  top_r;
  logic [2:0]  top_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] tags_r;
  logic [15:0] tags_nxt;
  logic [15:0] stateWord_r;
  logic [1:0]  precSel_r;
  logic [1:0]  rndSel_r;
  logic        precApply_r;
  logic        rndApply_r;
  logic        carry_r;
  logic        parity_r;
  logic        zero_r;

  // opcode decode
  wire isInit  = opValid && (opCode == FSCW_OP_INIT);
  wire isClex  = opValid && (opCode == FSCW_OP_CLEX);
  wire isLdenv = opValid && (opCode == FSCW_OP_LDENV);
  wire isStenv = opValid && (opCode == FSCW_OP_STENV);
  wire isSave  = opValid && (opCode == FSCW_OP_SAVE);
  wire isRstor = opValid && (opCode == FSCW_OP_RSTOR);
  wire isLdcw  = opValid && (opCode == FSCW_OP_LDCW);
  wire isArith = opValid && (opCode == FSCW_OP_ARITH);
  wire isTrig  = opValid && (opCode == FSCW_OP_TRIG);
  wire isCond  = opValid && (opCode == FSCW_OP_COND);
  wire isStack = opValid && (opCode == FSCW_OP_STACK);
  wire isSw    = opValid && (opCode == FSCW_OP_STSW);
  wire loadImg = isLdenv || isRstor;
  wire excClr  = isInit || isClex || isLdenv || isSave || isRstor;
  wire datapathOp = isArith || isTrig || isCond || isStack;

  // stack fault is an invalid operation by definition
  wire sfEvent = datapathOp && stackFault;
  wire [5:0] excIn = datapathOp
    ? (excRaised | (sfEvent ? 6'h01 << `FSCW_EXC_INVALID : `FSCW_EXC_NONE))
    : `FSCW_EXC_NONE;

  // fields of the memory image word
  wire [5:0] excImg  = memWord[`FSCW_SW_EXC_HI:`FSCW_SW_EXC_LO];
  wire       sfImg   = memWord[`FSCW_SW_STKFLT];
  wire [3:0] condImg = {memWord[`FSCW_SW_COND3], memWord[`FSCW_SW_COND2],
                        memWord[`FSCW_SW_COND1], memWord[`FSCW_SW_COND0]};
  wire [2:0] topImg  = memWord[`FSCW_SW_TOP_HI:`FSCW_SW_TOP_LO];

  // sticky flags hold; loads take the memory image as written
  always_comb
  begin
    if (loadImg)
      excFlags_nxt = excImg;
    else if (excClr)
      excFlags_nxt = `FSCW_EXC_NONE;
    else
      excFlags_nxt = excFlags_r | excIn;
  end

  always_comb
  begin
    if (loadImg)
      stackFaultFlag_nxt = sfImg;
    else if (excClr)
      stackFaultFlag_nxt = 1'b0;
    else
      stackFaultFlag_nxt = stackFaultFlag_r | sfEvent;
  end

  // condition bits: {cond3, cond2, cond1, cond0}
  always_comb
  begin
    cond_nxt = cond_r;
    if (loadImg)
      cond_nxt = condImg;
    else if (isInit || isSave)
      cond_nxt = `FSCW_COND_NONE;
    else if (sfEvent)
    begin
      // reduction outcome still reported beside the fault direction
      cond_nxt[1] = stackOverflow;
      if (isTrig)
        cond_nxt[2] = trigTooLarge;
    end
    else if (isArith)
      cond_nxt[1] = roundedUp;
    else if (isTrig)
    begin
      cond_nxt[2] = trigTooLarge;
      if (!trigTooLarge)
        cond_nxt[1] = roundedUp;
    end
    else if (isCond)
      cond_nxt = compareCond;
  end

  // push decrements top, pop increments
  always_comb
  begin
    top_nxt = top_r;
    if (loadImg)
      top_nxt = topImg;
    else if (isInit)
      top_nxt = `FSCW_TOP_INIT;
    else if (datapathOp && (stackMove == FSCW_STK_PUSH))
      top_nxt = top_r - `FSCW_TOP_ONE;
    else if (datapathOp && (stackMove == FSCW_STK_POP))
      top_nxt = top_r + `FSCW_TOP_ONE;
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (isInit)
      ctrl_nxt = `FSCW_CW_INIT;
    else if (isLdcw || loadImg)
      ctrl_nxt = memWord;
  end

  // fields of the control word that the next edge will hold
  wire [5:0] maskNxt = ctrl_nxt[`FSCW_CW_MASK_HI:`FSCW_CW_MASK_LO];
  wire [1:0] precNxt = ctrl_nxt[`FSCW_CW_PREC_HI:`FSCW_CW_PREC_LO];
  wire [1:0] rndNxt  = ctrl_nxt[`FSCW_CW_RND_HI:`FSCW_CW_RND_LO];

  // tags per physical register
  genvar g;
  generate
    for (g = 0; g < `FSCW_NREGS; g = g + 1)
    begin : gTag
      wire [1:0] tagOld   = tags_r[2*g+1:2*g];
      wire [1:0] tagImg   = memTags[2*g+1:2*g];
      wire [1:0] tagExact = exactTags[2*g+1:2*g];
      wire [1:0] tagMark  = tagFull ? `FSCW_TAG_VALID : `FSCW_TAG_EMPTY;
      wire       tagHit   = datapathOp && tagWrite && (tagReg == 3'(g));
      // only stores see exact classes; loads take the image tags; everything else marks empty or full
      assign tags_nxt[2*g+1:2*g] = isInit              ? `FSCW_TAG_EMPTY :
                                   loadImg             ? tagImg          :
                                   (isStenv || isSave) ? tagExact        :
                                   tagHit              ? tagMark         :
                                                         tagOld;
    end
  endgenerate

  // error summary from unmasked flags
  wire errSum = |(excFlags_nxt & ~maskNxt);
  wire [15:0] swNxt = {errSum, top_nxt, cond_nxt[3], cond_nxt[2], cond_nxt[1],
                       cond_nxt[0], errSum, stackFaultFlag_nxt, excFlags_nxt};

  // arithmetic class steers where precision and rounding take effect
  wire precSelNxt_en = isArith;
  wire rndSelNxt_en  = isArith || isTrig;

  // one short register process per state item
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      excFlags_r <= `FSCW_EXC_NONE;
    else
      excFlags_r <= excFlags_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stackFaultFlag_r <= 1'b0;
    else
      stackFaultFlag_r <= stackFaultFlag_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cond_r <= `FSCW_COND_NONE;
    else
      cond_r <= cond_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      top_r <= `FSCW_TOP_INIT;
    else
      top_r <= top_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_r <= `FSCW_CW_INIT;
    else
      ctrl_r <= ctrl_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tags_r <= `FSCW_TW_INIT;
    else
      tags_r <= tags_nxt;
  end

  // whole word registered at once so bit 15 and bit 7 never part
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stateWord_r <= `FSCW_SW_INIT;
    else
      stateWord_r <= swNxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      precSel_r <= FSCW_PREC_64;
    else
      precSel_r <= precNxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rndSel_r <= FSCW_RND_NEAR;
    else
      rndSel_r <= rndNxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      precApply_r <= 1'b0;
    else
      precApply_r <= precSelNxt_en;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rndApply_r <= 1'b0;
    else
      rndApply_r <= rndSelNxt_en;
  end

  // copy takes the bits held before this instruction
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      carry_r <= 1'b0;
    else if (isSw)
      carry_r <= cond_r[0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      parity_r <= 1'b0;
    else if (isSw)
      parity_r <= cond_r[2];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      zero_r <= 1'b0;
    else if (isSw)
      zero_r <= cond_r[3];
  end

  always_comb
  begin
    fpu_state_word          = stateWord_r;
    fpu_option_word         = ctrl_r;
    register_occupancy_tags = tags_r;
    precision_select        = precSel_r;
    roundingSelect          = rndSel_r;
    precisionApplies        = precApply_r;
    roundingApplies         = rndApply_r;
    integer_carry_flag      = carry_r;
    integer_parity_flag     = parity_r;
    integer_zero_flag       = zero_r;
  end

endmodule

// ===== test/fscw_iu_model.sv
`timescale 1ns/1ps
module fscw_iu_model
  import fscw_pkg::*;
(
  // clock
  input wire logic    clk,
  // escape strobe
  output logic        opValid,
  output fscw_op_t    opCode,
  output logic [15:0] memWord
);
  initial
  begin
    opValid = 1'b0;
    opCode  = FSCW_OP_NONE;
    memWord = 16'h0000;
  end
  // one-cycle strobe; dropped image word inverted so stale data never matches
  task automatic issue(input fscw_op_t op, input logic [15:0] w);
    @(negedge clk);
    opValid = 1'b1;
    opCode  = op;
    memWord = w;
    @(negedge clk);
    opValid = 1'b0;
    opCode  = FSCW_OP_NONE;
    memWord = ~w;
  endtask
endmodule

// ===== test/fscw_state_words_sva.sv
`timescale 1ns/1ps
module fscw_state_words_sva
  import fscw_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // instruction side
  input wire logic        opValid,
  input wire fscw_op_t    opCode,
  input wire logic [15:0] memWord,
  input wire logic        stackFault,
  input wire logic        stackOverflow,
  input wire logic        roundedUp,
  input wire logic        trigTooLarge,
  // watched outputs
  input wire logic [15:0] fpu_state_word,
  input wire logic [15:0] fpu_option_word,
  input wire logic [1:0]  precision_select,
  input wire logic        precisionApplies,
  input wire logic        roundingApplies,
  input wire logic        integer_carry_flag,
  input wire logic        integer_parity_flag,
  input wire logic        integer_zero_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire isArith = opValid && opCode == FSCW_OP_ARITH;
  property p_mirror; fpu_state_word[15] == fpu_state_word[7]; endproperty
  a_mirror: assert property (p_mirror) else $error("bit 15 differs from bit 7");
  property p_summary;
    fpu_state_word[7] == |(fpu_state_word[5:0] & ~fpu_option_word[5:0]);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");
  property p_sticky;
    !(opValid && opCode inside {FSCW_OP_INIT, FSCW_OP_CLEX, FSCW_OP_LDENV, FSCW_OP_SAVE,
      FSCW_OP_RSTOR}) |=> (fpu_state_word[5:0] & $past(fpu_state_word[5:0]))
      == $past(fpu_state_word[5:0]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared");
  property p_fault;
    isArith && stackFault |=> fpu_state_word[6] && fpu_state_word[0]
      && fpu_state_word[9] == $past(stackOverflow);
  endproperty
  a_fault: assert property (p_fault) else $error("stack fault report wrong");
  property p_roundUp; isArith && !stackFault |=> fpu_state_word[9] == $past(roundedUp); endproperty
  a_roundUp: assert property (p_roundUp) else $error("roundup bit wrong");
  property p_trig;
    opValid && opCode == FSCW_OP_TRIG |=> fpu_state_word[10] == $past(trigTooLarge);
  endproperty
  a_trig: assert property (p_trig) else $error("reduction bit wrong");
  property p_ldcw;
    opValid && opCode == FSCW_OP_LDCW |=> fpu_option_word == $past(memWord)
      && precision_select == $past(memWord[9:8]);
  endproperty
  a_ldcw: assert property (p_ldcw) else $error("option load wrong");
  property p_ldenv;
    opValid && opCode inside {FSCW_OP_LDENV, FSCW_OP_RSTOR}
      |=> fpu_state_word[11:8] == $past(memWord[11:8]);
  endproperty
  a_ldenv: assert property (p_ldenv) else $error("condition load wrong");
  property p_applies;
    opValid |=> precisionApplies == ($past(opCode) == FSCW_OP_ARITH)
      && roundingApplies == ($past(opCode) inside {FSCW_OP_ARITH, FSCW_OP_TRIG});
  endproperty
  a_applies: assert property (p_applies) else $error("applies flag wrong");
  property p_flags;
    opValid && opCode == FSCW_OP_STSW |=> integer_carry_flag == $past(fpu_state_word[8])
      && integer_parity_flag == $past(fpu_state_word[10])
      && integer_zero_flag == $past(fpu_state_word[11]);
  endproperty
  a_flags: assert property (p_flags) else $error("integer flag copy wrong");
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fscw_pkg::*;
  logic clk = 1'b0, rst = 1'b1, stackFault = 1'b0, stackOverflow = 1'b0;
  logic roundedUp = 1'b0, trigTooLarge = 1'b0, tagWrite = 1'b0, tagFull = 1'b0;
  logic [5:0] excRaised = 6'h00;
  logic [3:0] compareCond = 4'h0;
  logic [2:0] tagReg = 3'h0;
  logic [15:0] memTags = 16'h0000, exactTags = 16'h0000;
  fscw_stk_t stackMove = FSCW_STK_NONE;
  wire opValid, precisionApplies, roundingApplies;
  wire integer_carry_flag, integer_parity_flag, integer_zero_flag;
  fscw_op_t opCode;
  wire [15:0] memWord, fpu_state_word, fpu_option_word, register_occupancy_tags;
  wire [1:0] precision_select, roundingSelect;
  int failures = 0, checks_done = 0;
  always #12.5 clk = ~clk;
  fscw_iu_model i_iu (.clk, .opValid, .opCode, .memWord);
  fscw_state_words i_dut (.clk, .rst, .opValid, .opCode, .memWord, .memTags, .excRaised,
    .stackFault, .stackOverflow, .roundedUp, .trigTooLarge, .compareCond, .stackMove,
    .tagReg, .tagWrite, .tagFull, .exactTags, .fpu_state_word, .fpu_option_word,
    .register_occupancy_tags, .precision_select, .roundingSelect, .precisionApplies,
    .roundingApplies, .integer_carry_flag, .integer_parity_flag, .integer_zero_flag);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input fscw_op_t c, input logic [15:0] w = 16'h0000);
    i_iu.issue(c, w);
  endtask
  task automatic t_options;
    for (int r = 0; r < 4; r++)
      for (int p = 0; p < 4; p++)
        if (p != 1)
        begin
          op(FSCW_OP_LDCW, {4'h0, r[1:0], p[1:0], 8'h3F});
          chk(fpu_option_word, {4'h0, r[1:0], p[1:0], 8'h3F});
          chk({14'h0, precision_select}, 16'(p));
          chk({14'h0, roundingSelect}, 16'(r));
        end
    $display("done options");
  endtask
  task automatic t_flags;
    op(FSCW_OP_LDCW, 16'h037E);
    excRaised = 6'h20;
    roundedUp = 1'b1;
    op(FSCW_OP_ARITH);
    chk(fpu_state_word & 16'h82FF, 16'h0220);
    chk({14'h0, precisionApplies, roundingApplies}, 16'h0003);
    excRaised = 6'h00;
    stackFault = 1'b1;
    stackOverflow = 1'b1;
    op(FSCW_OP_ARITH);
    chk(fpu_state_word & 16'h82FF, 16'h82E1);
    stackFault = 1'b0;
    op(FSCW_OP_STACK);
    chk(fpu_state_word & 16'h00FF, 16'h00E1);
    op(FSCW_OP_CLEX);
    chk(fpu_state_word & 16'h80FF, 16'h0000);
    stackFault = 1'b1;
    stackOverflow = 1'b0;
    op(FSCW_OP_ARITH);
    chk(fpu_state_word & 16'h0241, 16'h0041);
    stackFault = 1'b0;
    trigTooLarge = 1'b1;
    op(FSCW_OP_TRIG);
    chk(fpu_state_word & 16'h0400, 16'h0400);
    trigTooLarge = 1'b0;
    op(FSCW_OP_TRIG);
    chk(fpu_state_word & 16'h0600, 16'h0200);
    chk({14'h0, precisionApplies, roundingApplies}, 16'h0001);
    $display("done flags");
  endtask
  task automatic t_stack;
    stackMove = FSCW_STK_PUSH;
    tagReg = 3'h7;
    tagWrite = 1'b1;
    tagFull = 1'b1;
    op(FSCW_OP_STACK);
    chk({13'h0, fpu_state_word[14:12]}, 16'h0007);
    chk(register_occupancy_tags, 16'h3FFF);
    stackMove = FSCW_STK_POP;
    tagFull = 1'b0;
    op(FSCW_OP_STACK);
    chk({13'h0, fpu_state_word[14:12]}, 16'h0000);
    chk(register_occupancy_tags, 16'hFFFF);
    tagWrite = 1'b0;
    stackMove = FSCW_STK_NONE;
    $display("done stack");
  endtask
  task automatic t_env;
    memTags = 16'h0FF0;
    op(FSCW_OP_LDENV, 16'h4D00);
    chk(fpu_state_word & 16'h0F00, 16'h0D00);
    chk({13'h0, fpu_state_word[14:12]}, 16'h0004);
    chk(register_occupancy_tags, 16'h0FF0);
    op(FSCW_OP_STSW);
    // condition bits after the copy are not judged
    chk({13'h0, integer_zero_flag, integer_parity_flag, integer_carry_flag}, 16'h0007);
    exactTags = 16'h1B2D;
    op(FSCW_OP_SAVE);
    chk(register_occupancy_tags, 16'h1B2D);
    chk(fpu_state_word & 16'h0F00, 16'h0000);
    compareCond = 4'h5;
    op(FSCW_OP_COND);
    chk(fpu_state_word & 16'h0F00, 16'h0500);
    op(FSCW_OP_INIT);
    chk(fpu_state_word & 16'h0F00, 16'h0000);
    chk(fpu_option_word, 16'h037F);
    chk(register_occupancy_tags, 16'hFFFF);
    $display("done env");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(fpu_state_word, 16'h0000);
    chk(fpu_option_word, 16'h037F);
    chk(register_occupancy_tags, 16'hFFFF);
    chk({12'h0, precision_select, roundingSelect}, 16'h000C);
    $display("done reset");
    t_options();
    t_flags();
    t_stack();
    t_env();
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
bind fscw_state_words fscw_state_words_sva i_sva (.clk, .rst, .opValid, .opCode, .memWord,
  .stackFault, .stackOverflow, .roundedUp, .trigTooLarge, .fpu_state_word, .fpu_option_word,
  .precision_select, .precisionApplies, .roundingApplies, .integer_carry_flag,
  .integer_parity_flag, .integer_zero_flag);
